// *** acqcfg_regs.svh ***
// Register offsets, field positions and reset values for the acquisition config bank
`ifndef ACQCFG_REGS_SVH
`define ACQCFG_REGS_SVH
// ****************************************************************
// Register offsets on the control bus
// ****************************************************************
`define ACQCFG_SNR_TWO_ADDR 7'h4e
`define ACQCFG_DC_THR_ADDR 7'h50
`define ACQCFG_PRE_LEAD_ADDR 7'h52
`define ACQCFG_PRE_LAG_ADDR 7'h54
`define ACQCFG_PAY_LEAD_ADDR 7'h56
`define ACQCFG_PAY_LAG_ADDR 7'h58
`define ACQCFG_FAR_ADDR 7'h5a
`define ACQCFG_TIMELINE_ADDR 7'h5c
`define ACQCFG_ACQ_THR_ADDR 7'h5e
`define ACQCFG_LONG_SEED_ADDR 7'h60
`define ACQCFG_SHORT_SEED_ADDR 7'h62
`define ACQCFG_TEST_BUS_ADDR 7'h64
// ****************************************************************
// Field positions
// ****************************************************************
`define ACQCFG_SNR_TWO_MSB 4
`define ACQCFG_SIX_MSB 5
`define ACQCFG_SEED_MSB 6
`define ACQCFG_BIT7 7
`define ACQCFG_BIT6 6
`define ACQCFG_SEED_SEL_BIT 3
// ****************************************************************
// Reset value and answer for unmapped reads
// ****************************************************************
`define ACQCFG_RESET_VAL 8'h00
`define ACQCFG_UNMAPPED_VAL 8'h00
// Log2 of 2^16 / 32: rate = N * 32 / 2^16 = N >> 11
`define ACQCFG_FAR_SHIFT 11
// Log2 of 32: the rate scaled by 2^16 is N << 5
`define ACQCFG_FAR_MUL_SHIFT 5
`endif

// *** acqcfg_pkg.sv ***
// Types shared by the acquisition config register bank
`default_nettype none
package acqcfg_pkg;
  typedef logic [7:0] acqcfg_byte_t;
  typedef logic [6:0] acqcfg_addr_t;
  typedef logic [5:0] acqcfg_six_t;
  typedef logic [6:0] acqcfg_seed_t;
  // Read view of the dual-view status registers
  typedef enum logic [0:0] {
    ACQCFG_VIEW_B = 1'b0,
    ACQCFG_VIEW_A = 1'b1
  } acqcfg_view_t;
endpackage : acqcfg_pkg
`default_nettype wire

// *** acqcfg_regs_top.sv ***
// Acquisition threshold and loop coefficient register bank with control-bus slave
`default_nettype none
`include "acqcfg_regs.svh"

module acqcfg_regs_top (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  // Control bus, same clock domain
  input wire acqcfg_pkg::acqcfg_addr_t bus_addr_i,
  input wire acqcfg_pkg::acqcfg_byte_t bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [7:0] bus_rdata_o,
  // Live receive-path values
  input wire acqcfg_pkg::acqcfg_byte_t test_bus_i,
  input wire acqcfg_pkg::acqcfg_byte_t received_strength_level_i,
  input wire acqcfg_pkg::acqcfg_byte_t background_level_i,
  input wire logic preamble_control_seed_sel_i,
  // Configuration outputs to the acquisition path
  output acqcfg_pkg::acqcfg_byte_t snr_threshold_two_o,
  output logic dc_offset_enable_o,
  output acqcfg_pkg::acqcfg_six_t preamble_lead_o,
  output acqcfg_pkg::acqcfg_six_t preamble_lag_o,
  output acqcfg_pkg::acqcfg_six_t payload_lead_o,
  output acqcfg_pkg::acqcfg_six_t payload_lag_o,
  output logic [7:0] false_alarm_rate_n_o,
  output logic [23:0] false_alarm_rate_q16_o,
  output logic force_short_preamble_o,
  output logic diversity_use_strength_o,
  output acqcfg_pkg::acqcfg_six_t verify_threshold_o,
  output logic far_adjust_enable_o,
  output logic acquire_with_energy_o,
  output acqcfg_pkg::acqcfg_six_t detect_threshold_o,
  output acqcfg_pkg::acqcfg_seed_t scrambler_seed_o,
  output acqcfg_pkg::acqcfg_view_t status_view_o
);
  import acqcfg_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta;
  logic rst_sync_n;

  // Asynchronous assert, two-flop synchronous release
  // Every flop behind this copy leaves reset on the same edge
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ****************************************************************
  // Input synchronisers for pin-side values
  // ****************************************************************
  acqcfg_byte_t tb_meta, tb_sync;
  acqcfg_byte_t rsl_meta, rsl_sync;
  acqcfg_byte_t bgl_meta, bgl_sync;
  logic sel_meta, sel_sync;

  // Two flops before any logic reads them
  // Multi-bit levels may settle bit by bit one edge apart; they move slowly
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tb_meta <= `ACQCFG_RESET_VAL;
      tb_sync <= `ACQCFG_RESET_VAL;
      rsl_meta <= `ACQCFG_RESET_VAL;
      rsl_sync <= `ACQCFG_RESET_VAL;
      bgl_meta <= `ACQCFG_RESET_VAL;
      bgl_sync <= `ACQCFG_RESET_VAL;
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
    end else if (clk_en_i) begin
      tb_meta <= test_bus_i;
      tb_sync <= tb_meta;
      rsl_meta <= received_strength_level_i;
      rsl_sync <= rsl_meta;
      bgl_meta <= background_level_i;
      bgl_sync <= bgl_meta;
      sel_meta <= preamble_control_seed_sel_i;
      sel_sync <= sel_meta;
    end
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  acqcfg_byte_t snr_threshold_two;
  acqcfg_byte_t dc_offset_threshold;
  acqcfg_byte_t preamble_lead_coefficient;
  acqcfg_byte_t preamble_lag_coefficient;
  acqcfg_byte_t payload_lead_coefficient;
  acqcfg_byte_t payload_lag_coefficient;
  acqcfg_byte_t false_alarm_rate_target;
  acqcfg_byte_t acquisition_timeline;
  acqcfg_byte_t acquisition_thresholds;
  acqcfg_byte_t long_preamble_seed;
  acqcfg_byte_t short_seed_and_view_select;

  // Write decode helper
  function automatic logic hit(input acqcfg_addr_t a, input acqcfg_addr_t off);
    hit = (a == off);
  endfunction : hit

  // Whole byte stored, unused bits included
  // Writes to the read-only test bus address match no decode and are dropped
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      snr_threshold_two <= `ACQCFG_RESET_VAL;
      dc_offset_threshold <= `ACQCFG_RESET_VAL;
      preamble_lead_coefficient <= `ACQCFG_RESET_VAL;
      preamble_lag_coefficient <= `ACQCFG_RESET_VAL;
      payload_lead_coefficient <= `ACQCFG_RESET_VAL;
      payload_lag_coefficient <= `ACQCFG_RESET_VAL;
      false_alarm_rate_target <= `ACQCFG_RESET_VAL;
      acquisition_timeline <= `ACQCFG_RESET_VAL;
      acquisition_thresholds <= `ACQCFG_RESET_VAL;
      long_preamble_seed <= `ACQCFG_RESET_VAL;
      short_seed_and_view_select <= `ACQCFG_RESET_VAL;
    end else if (clk_en_i && bus_wr_i) begin
      if (hit(bus_addr_i, `ACQCFG_SNR_TWO_ADDR)) begin
        snr_threshold_two <= bus_wdata_i;
      end
      if (hit(bus_addr_i, `ACQCFG_DC_THR_ADDR)) begin
        dc_offset_threshold <= bus_wdata_i;
      end
      if (hit(bus_addr_i, `ACQCFG_PRE_LEAD_ADDR)) begin
        preamble_lead_coefficient <= bus_wdata_i;
      end
      if (hit(bus_addr_i, `ACQCFG_PRE_LAG_ADDR)) begin
        preamble_lag_coefficient <= bus_wdata_i;
      end
      if (hit(bus_addr_i, `ACQCFG_PAY_LEAD_ADDR)) begin
        payload_lead_coefficient <= bus_wdata_i;
      end
      if (hit(bus_addr_i, `ACQCFG_PAY_LAG_ADDR)) begin
        payload_lag_coefficient <= bus_wdata_i;
      end
      if (hit(bus_addr_i, `ACQCFG_FAR_ADDR)) begin
        false_alarm_rate_target <= bus_wdata_i;
      end
      if (hit(bus_addr_i, `ACQCFG_TIMELINE_ADDR)) begin
        acquisition_timeline <= bus_wdata_i;
      end
      if (hit(bus_addr_i, `ACQCFG_ACQ_THR_ADDR)) begin
        acquisition_thresholds <= bus_wdata_i;
      end
      if (hit(bus_addr_i, `ACQCFG_LONG_SEED_ADDR)) begin
        long_preamble_seed <= bus_wdata_i;
      end
      if (hit(bus_addr_i, `ACQCFG_SHORT_SEED_ADDR)) begin
        short_seed_and_view_select <= bus_wdata_i;
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  acqcfg_byte_t next_rdata;

  // Readback mux; unmapped addresses answer zero
  // Status views are served elsewhere; only the test bus reads live here
  // A read and a write in one cycle return the old value
  always_comb begin
    case (bus_addr_i)
      `ACQCFG_SNR_TWO_ADDR: next_rdata = snr_threshold_two;
      `ACQCFG_DC_THR_ADDR: next_rdata = dc_offset_threshold;
      `ACQCFG_PRE_LEAD_ADDR: next_rdata = preamble_lead_coefficient;
      `ACQCFG_PRE_LAG_ADDR: next_rdata = preamble_lag_coefficient;
      `ACQCFG_PAY_LEAD_ADDR: next_rdata = payload_lead_coefficient;
      `ACQCFG_PAY_LAG_ADDR: next_rdata = payload_lag_coefficient;
      `ACQCFG_FAR_ADDR: next_rdata = false_alarm_rate_target;
      `ACQCFG_TIMELINE_ADDR: next_rdata = acquisition_timeline;
      `ACQCFG_ACQ_THR_ADDR: next_rdata = acquisition_thresholds;
      `ACQCFG_LONG_SEED_ADDR: next_rdata = long_preamble_seed;
      `ACQCFG_SHORT_SEED_ADDR: next_rdata = short_seed_and_view_select;
      `ACQCFG_TEST_BUS_ADDR: next_rdata = tb_sync; // Same in both views
      default: next_rdata = `ACQCFG_UNMAPPED_VAL;
    endcase
  end

  // Read data registered one cycle after the read strobe
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_rdata_o <= `ACQCFG_RESET_VAL;
    end else if (clk_en_i && bus_rd_i) begin
      bus_rdata_o <= next_rdata;
    end
  end

  // ****************************************************************
  // Configuration decode to the acquisition path
  // ****************************************************************
  logic [8:0] dc_limit;

  // Threshold plus background, one bit of headroom
  // An eight-bit sum would wrap and open the gate at high background
  assign dc_limit = {3'b000, dc_offset_threshold[`ACQCFG_SIX_MSB:0]} + {1'b0, bgl_sync};

  // Weight-choice SNR threshold; bits above the field read as zero
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      snr_threshold_two_o <= `ACQCFG_RESET_VAL;
    end else if (clk_en_i) begin
      snr_threshold_two_o <= {3'b000, snr_threshold_two[`ACQCFG_SNR_TWO_MSB:0]};
    end
  end

  // DC offset gate; equal levels keep it off
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dc_offset_enable_o <= 1'b0;
    end else if (clk_en_i) begin
      dc_offset_enable_o <= ({1'b0, rsl_sync} > dc_limit);
    end
  end

  // Tracking loop coefficients; unused top bits never reach the loop
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      preamble_lead_o <= '0;
      preamble_lag_o <= '0;
      payload_lead_o <= '0;
      payload_lag_o <= '0;
    end else if (clk_en_i) begin
      preamble_lead_o <= preamble_lead_coefficient[`ACQCFG_SIX_MSB:0];
      preamble_lag_o <= preamble_lag_coefficient[`ACQCFG_SIX_MSB:0];
      payload_lead_o <= payload_lead_coefficient[`ACQCFG_SIX_MSB:0];
      payload_lag_o <= payload_lag_coefficient[`ACQCFG_SIX_MSB:0];
    end
  end

  // False alarm rate, raw and as a fraction scaled by 2^16
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      false_alarm_rate_n_o <= `ACQCFG_RESET_VAL;
      false_alarm_rate_q16_o <= '0;
    end else if (clk_en_i) begin
      false_alarm_rate_n_o <= false_alarm_rate_target;
      // N*32 as a left shift; headroom keeps the top bits of N
      false_alarm_rate_q16_o <= {16'h0000, false_alarm_rate_target} << `ACQCFG_FAR_MUL_SHIFT;
    end
  end

  // Timeline controls for preamble handling and verify
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      force_short_preamble_o <= 1'b0;
      diversity_use_strength_o <= 1'b0;
      verify_threshold_o <= '0;
    end else if (clk_en_i) begin
      force_short_preamble_o <= acquisition_timeline[`ACQCFG_BIT7];
      diversity_use_strength_o <= acquisition_timeline[`ACQCFG_BIT6];
      verify_threshold_o <= acquisition_timeline[`ACQCFG_SIX_MSB:0];
    end
  end

  // Detect controls; rate logic runs while bit 7 is clear
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      far_adjust_enable_o <= 1'b0;
      acquire_with_energy_o <= 1'b0;
      detect_threshold_o <= '0;
    end else if (clk_en_i) begin
      far_adjust_enable_o <= ~acquisition_thresholds[`ACQCFG_BIT7];
      acquire_with_energy_o <= acquisition_thresholds[`ACQCFG_BIT6];
      detect_threshold_o <= acquisition_thresholds[`ACQCFG_SIX_MSB:0];
    end
  end

  // Scrambler seed source and status view
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      scrambler_seed_o <= '0;
      status_view_o <= ACQCFG_VIEW_B;
    end else if (clk_en_i) begin
      // Seed source picked by preamble control bit
      scrambler_seed_o <= sel_sync ? short_seed_and_view_select[`ACQCFG_SEED_MSB:0]
                                   : long_preamble_seed[`ACQCFG_SEED_MSB:0];
      // View select for the dual-view status registers
      status_view_o <= acqcfg_view_t'(short_seed_and_view_select[`ACQCFG_BIT7]);
    end
  end

endmodule : acqcfg_regs_top
`default_nettype wire

// *** acqcfg_regs_properties.sv ***
// Port-level checker for the acquisition config register bank
`default_nettype none
module acqcfg_regs_checker (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire acqcfg_pkg::acqcfg_addr_t bus_addr_i,
  input wire acqcfg_pkg::acqcfg_byte_t bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_rdata_o,
  input wire acqcfg_pkg::acqcfg_byte_t snr_threshold_two_o,
  input wire acqcfg_pkg::acqcfg_six_t preamble_lead_o,
  input wire acqcfg_pkg::acqcfg_six_t payload_lag_o,
  input wire logic [7:0] false_alarm_rate_n_o,
  input wire logic [23:0] false_alarm_rate_q16_o,
  input wire logic force_short_preamble_o,
  input wire logic diversity_use_strength_o,
  input wire acqcfg_pkg::acqcfg_six_t verify_threshold_o,
  input wire logic far_adjust_enable_o,
  input wire logic acquire_with_energy_o,
  input wire acqcfg_pkg::acqcfg_six_t detect_threshold_o,
  input wire acqcfg_pkg::acqcfg_view_t status_view_o
);
  import acqcfg_pkg::*;
  logic [7:0] wd1;
  logic [7:0] wd2;
  logic mapped;
  // Write data two edges back
  always_ff @(posedge ref_clk_i) begin
    wd1 <= bus_wdata_i;
    wd2 <= wd1;
  end
  // Even offsets of the bank
  assign mapped = bus_addr_i >= 7'h4e && bus_addr_i <= 7'h64 && !bus_addr_i[0];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // Write taken, then one more enabled edge
  sequence wr_s(logic [6:0] a);
    bus_wr_i && clk_en_i && bus_addr_i == a ##1 clk_en_i;
  endsequence
  // ****************
  // Assertions
  // ****************
  snr_field_a: assert property (wr_s(7'h4e) |=> snr_threshold_two_o == {3'h0, wd2[4:0]})
    else $error("snr threshold output wrong");
  lead_field_a: assert property (wr_s(7'h52) |=> preamble_lead_o == wd2[5:0])
    else $error("preamble lead output wrong");
  pay_lag_a: assert property (wr_s(7'h58) |=> payload_lag_o == wd2[5:0])
    else $error("payload lag output wrong");
  far_scale_a: assert property (false_alarm_rate_q16_o == {11'h0, false_alarm_rate_n_o, 5'h0})
    else $error("false alarm scale wrong");
  timeline_bits_a: assert property (wr_s(7'h5c) |=>
    {force_short_preamble_o, diversity_use_strength_o, verify_threshold_o} == wd2)
    else $error("timeline outputs wrong");
  thr_ctrl_a: assert property (wr_s(7'h5e) |=>
    {far_adjust_enable_o, acquire_with_energy_o, detect_threshold_o} == {~wd2[7], wd2[6:0]})
    else $error("threshold control outputs wrong");
  view_sel_a: assert property (wr_s(7'h62) |=> status_view_o == wd2[7])
    else $error("view select wrong");
  rdata_hold_a: assert property (!(bus_rd_i && clk_en_i) |=> $stable(bus_rdata_o))
    else $error("read data moved without a read");
  unmapped_rd_a: assert property (bus_rd_i && clk_en_i && !mapped |=> bus_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  cover property (wr_s(7'h5e));
  cover property (bus_rd_i && clk_en_i && bus_addr_i == 7'h64);
  cover property (!clk_en_i && bus_wr_i);
endmodule : acqcfg_regs_checker
bind acqcfg_regs_top acqcfg_regs_checker i_chk (.*);
`default_nettype wire

// *** acqcfg_host_model.sv ***
// Behavioural control-bus host driving the config bank
`default_nettype none
module acqcfg_host_model (
  input wire logic ref_clk_i,
  output acqcfg_pkg::acqcfg_addr_t bus_addr_o,
  output acqcfg_pkg::acqcfg_byte_t bus_wdata_o,
  output logic bus_wr_o,
  output logic bus_rd_o,
  input wire logic [7:0] bus_rdata_i
);
  timeunit 1ns;
  timeprecision 100ps;
  import acqcfg_pkg::*;
  // Idle bus at time zero
  initial begin
    bus_addr_o = 7'h00;
    bus_wdata_o = 8'h00;
    bus_wr_o = 1'b0;
    bus_rd_o = 1'b0;
  end
  // Launch just after an edge, hold over the taking edge
  task automatic drive(input logic w, input logic r, input acqcfg_addr_t a, input acqcfg_byte_t d);
    bus_wr_o = w;
    bus_rd_o = r;
    bus_addr_o = a;
    bus_wdata_o = d;
    @(posedge ref_clk_i);
    #1;
  endtask : drive
  task automatic write_reg(input acqcfg_addr_t a, input acqcfg_byte_t d);
    drive(1'b1, 1'b0, a, d);
  endtask : write_reg
  // Unused data lines show no stale value; data taken at the read edge
  task automatic read_reg(input acqcfg_addr_t a, output acqcfg_byte_t q);
    drive(1'b0, 1'b1, a, ~bus_wdata_o);
    q = bus_rdata_i;
  endtask : read_reg
  task automatic idle();
    drive(1'b0, 1'b0, ~bus_addr_o, ~bus_wdata_o);
  endtask : idle
endmodule : acqcfg_host_model
`default_nettype wire

// *** acqcfg_regs_top_tb.sv ***
// Self-checking bench for the acquisition config bank
`default_nettype none
module acqcfg_regs_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import acqcfg_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, en = 1'b1, sel = 1'b0, wr, rd, dce, fs, div, fae, awe;
  acqcfg_addr_t addr;
  acqcfg_byte_t wdata, tbus = 8'h00, st = 8'h00, bg = 8'h00, snr;
  logic [7:0] rdata, farn;
  logic [23:0] q16;
  acqcfg_six_t plead, plag, ylead, ylag, ver, det;
  acqcfg_seed_t seed;
  acqcfg_view_t view;
  int num_errors = 0, n_compared = 0, cyc = 0;
  logic [7:0] vals [11] = '{8'hff, 8'hca, 8'he0, 8'hc0, 8'h60, 8'h9f, 8'h10, 8'hbf, 8'h7f,
    8'hd5, 8'h2b};
  always #4 clk = ~clk;
  acqcfg_host_model u_host (.ref_clk_i(clk), .bus_addr_o(addr), .bus_wdata_o(wdata),
    .bus_wr_o(wr), .bus_rd_o(rd), .bus_rdata_i(rdata));
  acqcfg_regs_top i_dut (.ref_clk_i(clk), .rstn_i(rstn), .clk_en_i(en), .bus_addr_i(addr),
    .bus_wdata_i(wdata), .bus_wr_i(wr), .bus_rd_i(rd), .bus_rdata_o(rdata),
    .test_bus_i(tbus), .received_strength_level_i(st), .background_level_i(bg),
    .preamble_control_seed_sel_i(sel), .snr_threshold_two_o(snr), .dc_offset_enable_o(dce),
    .preamble_lead_o(plead), .preamble_lag_o(plag), .payload_lead_o(ylead),
    .payload_lag_o(ylag), .false_alarm_rate_n_o(farn), .false_alarm_rate_q16_o(q16),
    .force_short_preamble_o(fs), .diversity_use_strength_o(div), .verify_threshold_o(ver),
    .far_adjust_enable_o(fae), .acquire_with_energy_o(awe), .detect_threshold_o(det),
    .scrambler_seed_o(seed), .status_view_o(view));
  // ****************
  // Helpers
  // ****************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    acqcfg_byte_t q;
    for (int i = 0; i < 11; i++) begin
      u_host.read_reg(7'h4e + 7'(2 * i), q);
      chk("reset read", 8'h00, q);
    end
    chk("far adjust", 1'b1, fae);
    $display("t_reset done");
  endtask : t_reset
  // Unused bits set, back-to-back writes, then full readback
  task automatic t_rw;
    acqcfg_byte_t q;
    for (int i = 0; i < 11; i++) u_host.write_reg(7'h4e + 7'(2 * i), vals[i]);
    wt(2);
    for (int i = 0; i < 11; i++) begin
      u_host.read_reg(7'h4e + 7'(2 * i), q);
      chk("readback", vals[i], q);
    end
    chk("snr two", 8'h1f, snr);
    chk("coeffs", {6'h20, 6'h00, 6'h20, 6'h1f}, {plead, plag, ylead, ylag});
    chk("far", {8'h10, 24'h200}, {farn, q16});
    chk("timeline", {1'b1, 1'b0, 6'h3f}, {fs, div, ver});
    chk("thr ctl", {1'b1, 1'b1, 6'h3f}, {fae, awe, det});
    chk("seed", {7'h55, 1'b0}, {seed, view});
    $display("t_rw done");
  endtask : t_rw
  task automatic t_acq;
    u_host.write_reg(7'h5c, 8'h40);
    u_host.write_reg(7'h5e, 8'h80);
    u_host.write_reg(7'h5a, 8'hff);
    wt(2);
    chk("timeline", {1'b0, 1'b1, 6'h00}, {fs, div, ver});
    chk("thr ctl", {1'b0, 1'b0, 6'h00}, {fae, awe, det});
    chk("far q16", 24'h1fe0, q16);
    $display("t_acq done");
  endtask : t_acq
  task automatic t_seed;
    sel = 1'b1;
    wt(4);
    chk("short seed", 7'h2b, seed);
    u_host.write_reg(7'h62, 8'hab);
    wt(2);
    chk("view a", 1'b1, view);
    sel = 1'b0;
    wt(4);
    chk("long seed", 7'h55, seed);
    $display("t_seed done");
  endtask : t_seed
  // Threshold 10 dB above a moving background
  task automatic t_dc;
    bg = 8'd20;
    st = 8'd30;
    wt(4);
    chk("dc equal", 1'b0, dce);
    st = 8'd31;
    wt(4);
    chk("dc above", 1'b1, dce);
    bg = 8'hff;
    st = 8'hff;
    wt(4);
    chk("dc wrap", 1'b0, dce);
    $display("t_dc done");
  endtask : t_dc
  task automatic t_tbus;
    acqcfg_byte_t q;
    tbus = 8'h96;
    wt(4);
    u_host.read_reg(7'h64, q);
    chk("tbus a", 8'h96, q);
    u_host.write_reg(7'h62, 8'h2b);
    u_host.write_reg(7'h64, 8'h00);
    u_host.read_reg(7'h64, q);
    chk("tbus b", 8'h96, q);
    u_host.read_reg(7'h4f, q);
    chk("odd addr", 8'h00, q);
    u_host.read_reg(7'h66, q);
    chk("past end", 8'h00, q);
    $display("t_tbus done");
  endtask : t_tbus
  // Write strobe while the clock enable is low
  task automatic t_freeze;
    acqcfg_byte_t q;
    en = 1'b0;
    u_host.write_reg(7'h4e, 8'h00);
    u_host.idle();
    en = 1'b1;
    u_host.read_reg(7'h4e, q);
    chk("frozen", 8'hff, q);
    $display("t_freeze done");
  endtask : t_freeze
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    wt(8);
    rstn = 1'b1;
    wt(3);
    t_reset();
    t_rw();
    t_acq();
    t_seed();
    t_dc();
    t_tbus();
    t_freeze();
    final_report();
  end
endmodule : acqcfg_regs_top_tb
`default_nettype wire
